//--- core/clkout_regs_pkg.sv
// How it works
// R1: Output one source: first divider when bit 7 is 0, third when 1; resets 1.
// R2: Output two source: first divider when bit 7 is 0, third when 1; resets 0.
// R3: Output one type field bits 5:4: 00 CMOS, 11 low-power HCSL; resets 11.
// R4: Output two type field bits 5:4: 00 CMOS, 11 low-power HCSL; resets 11.
// R5: Output one bit 1 sets CMOS slew: normal at 0, strong at 1; resets 0.
// R6: Output two bit 1 sets CMOS slew: normal at 0, strong at 1; resets 0.
// R7: Output one bit 0 enables second CMOS leg; resets 0.
// R8: Output two bit 0 enables second CMOS leg; resets 0.
// R9: Third register bit 7 low powers the whole chip down; resets 1.
// R10: Single output: 32 kHz free-run when bit 4 low, else bit 3 picks divider.
// R11: Bits 1 and 0 enable the two fourth-divider channels; both reset 0.
// R12: Software keeps reserved bits at reset values; they have no effect.
`default_nettype none

package clkout_regs_pkg;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] OFS_OUT_ONE = 8'h22;
  localparam logic [7:0] OFS_OUT_TWO = 8'h23;
  localparam logic [7:0] OFS_SINGLE  = 8'h24;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SRC_SEL_BIT  = 7;
  localparam int TYPE_HI_BIT  = 5;
  localparam int TYPE_LO_BIT  = 4;
  localparam int SLEW_BIT     = 1;
  localparam int LEG2_BIT     = 0;
  localparam int PWR_N_BIT    = 7;
  localparam int REF_FREE_BIT = 6;
  localparam int FREERUN_BIT  = 4;
  localparam int DIV_SEL_BIT  = 3;
  localparam int REF_EN_BIT   = 2;
  localparam int CH_B_BIT     = 1;
  localparam int CH_A_BIT     = 0;

  // ----------------------------------------
  // Reset values (reserved bits included)
  // ----------------------------------------
  localparam logic [7:0] RST_OUT_ONE = 8'hb4;
  localparam logic [7:0] RST_OUT_TWO = 8'h74;
  localparam logic [7:0] RST_SINGLE  = 8'h8c;

  // Writable bits; reserved bits hold their reset value
  localparam logic [7:0] WMASK_OUT   = 8'hb3;
  localparam logic [7:0] WMASK_SGL   = 8'hdf;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  typedef enum logic [1:0] {
    cmos_type           = 2'h0,
    type_reserved_a     = 2'h1,
    type_reserved_b     = 2'h2,
    low_power_hcsl_type = 2'h3
  } driver_type_t;

  // Source of each output as a small code
  typedef enum logic [1:0] {
    src_first_divider  = 2'h0,
    src_third_divider  = 2'h1,
    src_fourth_divider = 2'h2,
    src_fifth_divider  = 2'h3
  } source_t;

endpackage

`default_nettype wire

//--- core/diff_out_decode.sv
`default_nettype none

module diff_out_decode
  import clkout_regs_pkg::*;
(
  input  wire logic [7:0]                    cfg,
  output wire clkout_regs_pkg::source_t      source,
  output wire clkout_regs_pkg::driver_type_t driver_type,
  output wire logic                          slew_strong,
  output wire logic                          second_leg_en
);
  // Leg and slew only mean something in CMOS mode
  wire logic is_cmos;

  assign source        = cfg[SRC_SEL_BIT] ? src_third_divider : src_first_divider; // R1
  assign driver_type   = driver_type_t'(cfg[TYPE_HI_BIT:TYPE_LO_BIT]);              // R3
  assign is_cmos       = (driver_type == cmos_type);
  assign slew_strong   = is_cmos & cfg[SLEW_BIT];                                   // R5
  assign second_leg_en = is_cmos & cfg[LEG2_BIT];                                   // R7

endmodule

`default_nettype wire

//--- core/clock_output_control_regs.sv
`default_nettype none

module clock_output_control_regs
  import clkout_regs_pkg::*;
(
  // ----------------------------------------
  // Clock and reset
  // ----------------------------------------
  input  wire logic                          sys_clk,
  input  wire logic                          rst,
  // ----------------------------------------
  // Register access
  // ----------------------------------------
  input  wire logic [7:0]                    reg_addr,
  input  wire logic                          reg_wr,
  input  wire logic [7:0]                    reg_wdata,
  output logic      [7:0]                    reg_rdata,
  // ----------------------------------------
  // Output one
  // ----------------------------------------
  output clkout_regs_pkg::source_t           out_one_source,
  output clkout_regs_pkg::driver_type_t      out_one_driver_type,
  output logic                               out_one_slew_strength,
  output logic                               out_one_second_leg_enable,
  // ----------------------------------------
  // Output two
  // ----------------------------------------
  output clkout_regs_pkg::source_t           out_two_source,
  output clkout_regs_pkg::driver_type_t      out_two_driver_type,
  output logic                               out_two_slew_strength,
  output logic                               out_two_second_leg_enable,
  // ----------------------------------------
  // Chip power, single output and dividers
  // ----------------------------------------
  output logic                               chip_power_down,
  output logic                               single_out_slow_freerun,
  output clkout_regs_pkg::source_t           single_out_source,
  output logic                               ref_out_freerun,
  output logic                               ref_out_enable,
  output logic                               fourth_divider_channel_a_enable,
  output logic                               fourth_divider_channel_b_enable
);

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] one_ff;
  logic [7:0] two_ff;
  logic [7:0] sgl_ff;
  logic [7:0] nxt_one;
  logic [7:0] nxt_two;
  logic [7:0] nxt_sgl;

  wire logic hit_one;
  wire logic hit_two;
  wire logic hit_sgl;
  wire logic [7:0] rd_mux;

  // ----------------------------------------
  // Write decode
  // ----------------------------------------
  assign hit_one = reg_wr & (reg_addr == OFS_OUT_ONE);
  assign hit_two = reg_wr & (reg_addr == OFS_OUT_TWO);
  assign hit_sgl = reg_wr & (reg_addr == OFS_SINGLE);

  // Reserved bits keep reset value whatever software writes
  assign nxt_one = hit_one ? ((reg_wdata & WMASK_OUT) | (RST_OUT_ONE & ~WMASK_OUT)) : one_ff; // R12
  assign nxt_two = hit_two ? ((reg_wdata & WMASK_OUT) | (RST_OUT_TWO & ~WMASK_OUT)) : two_ff; // R12
  assign nxt_sgl = hit_sgl ? ((reg_wdata & WMASK_SGL) | (RST_SINGLE & ~WMASK_SGL)) : sgl_ff;  // R12

  // ----------------------------------------
  // Read back
  // ----------------------------------------
  // Unmapped offsets read as zero
  assign rd_mux = (reg_addr == OFS_OUT_ONE) ? one_ff :
                  (reg_addr == OFS_OUT_TWO) ? two_ff :
                  (reg_addr == OFS_SINGLE)  ? sgl_ff : 8'h00;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      one_ff <= RST_OUT_ONE; // R1
    end else begin
      one_ff <= nxt_one;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      two_ff <= RST_OUT_TWO; // R2
    end else begin
      two_ff <= nxt_two;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sgl_ff <= RST_SINGLE;  // R9
    end else begin
      sgl_ff <= nxt_sgl;
    end
  end

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic [7:0]   diff_cfg  [2];
  source_t      diff_src  [2];
  driver_type_t diff_type [2];
  logic         diff_slew [2];
  logic         diff_leg  [2];
  source_t      sgl_src;

  // Index 0 is output one, index 1 is output two
  assign diff_cfg[0] = nxt_one;
  assign diff_cfg[1] = nxt_two;

  // Same decode for both outputs; CMOS gating lives in the sub-block
  for (genvar ch = 0; ch < 2; ch++) begin : g_diff
    diff_out_decode diff_out_decode_inst (
      .cfg           (diff_cfg[ch]),
      .source        (diff_src[ch]),
      .driver_type   (diff_type[ch]),
      .slew_strong   (diff_slew[ch]),
      .second_leg_en (diff_leg[ch])
    );
  end

  // ----------------------------------------
  // Single output and divider fields
  // ----------------------------------------
  wire logic run_keep;
  wire logic divider_mode;
  wire logic ref_free;
  wire logic ref_on;
  wire logic ch_a_on;
  wire logic ch_b_on;

  assign run_keep     = nxt_sgl[PWR_N_BIT];   // R9
  assign divider_mode = nxt_sgl[FREERUN_BIT]; // R10
  assign ref_free     = nxt_sgl[REF_FREE_BIT];
  assign ref_on       = nxt_sgl[REF_EN_BIT];
  assign ch_a_on      = nxt_sgl[CH_A_BIT];    // R11
  assign ch_b_on      = nxt_sgl[CH_B_BIT];    // R11

  // Pick tracked in free-run too, so leaving free-run needs no second write
  assign sgl_src = nxt_sgl[DIV_SEL_BIT] ? src_fourth_divider : src_fifth_divider; // R10

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rd_mux;
    end
  end

  // ----------------------------------------
  // Outputs: decoded from next value so they track the register cycle for cycle
  // ----------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_one_source            <= src_third_divider;   // R1
      out_one_driver_type       <= low_power_hcsl_type; // R3
      out_one_slew_strength     <= 1'b0;                // R5
      out_one_second_leg_enable <= 1'b0;                // R7
    end else begin
      out_one_source            <= diff_src[0];         // R1
      out_one_driver_type       <= diff_type[0];        // R3
      out_one_slew_strength     <= diff_slew[0];        // R5
      out_one_second_leg_enable <= diff_leg[0];         // R7
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_two_source            <= src_first_divider;   // R2
      out_two_driver_type       <= low_power_hcsl_type; // R4
      out_two_slew_strength     <= 1'b0;                // R6
      out_two_second_leg_enable <= 1'b0;                // R8
    end else begin
      out_two_source            <= diff_src[1];         // R2
      out_two_driver_type       <= diff_type[1];        // R4
      out_two_slew_strength     <= diff_slew[1];        // R6
      out_two_second_leg_enable <= diff_leg[1];         // R8
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      chip_power_down         <= 1'b0;               // R9
      single_out_slow_freerun <= 1'b1;               // R10
      single_out_source       <= src_fourth_divider; // R10
    end else begin
      chip_power_down         <= ~run_keep;          // R9
      single_out_slow_freerun <= ~divider_mode;      // R10
      single_out_source       <= sgl_src;            // R10
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ref_out_freerun <= 1'b0;
      ref_out_enable  <= 1'b1;
    end else begin
      ref_out_freerun <= ref_free;
      ref_out_enable  <= ref_on;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fourth_divider_channel_a_enable <= 1'b0;    // R11
      fourth_divider_channel_b_enable <= 1'b0;    // R11
    end else begin
      fourth_divider_channel_a_enable <= ch_a_on; // R11
      fourth_divider_channel_b_enable <= ch_b_on; // R11
    end
  end

endmodule

`default_nettype wire

//--- dv/clkout_regs_asserts.sv
`default_nettype none

module clkout_regs_asserts
  import clkout_regs_pkg::*;
(
  input wire logic                          sys_clk,
  input wire logic                          rst,
  input wire logic [7:0]                    reg_addr,
  input wire logic                          reg_wr,
  input wire logic [7:0]                    reg_wdata,
  input wire clkout_regs_pkg::source_t      out_one_source,
  input wire clkout_regs_pkg::driver_type_t out_one_driver_type,
  input wire logic                          out_one_slew_strength,
  input wire clkout_regs_pkg::source_t      out_two_source,
  input wire logic                          out_two_second_leg_enable,
  input wire logic                          chip_power_down,
  input wire logic                          single_out_slow_freerun,
  input wire clkout_regs_pkg::source_t      single_out_source,
  input wire logic                          fourth_divider_channel_a_enable
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence wr_at(logic [7:0] a);
    reg_wr && reg_addr == a;
  endsequence

  src_one_a: assert property (wr_at(OFS_OUT_ONE) |=>
    out_one_source == ($past(reg_wdata[7]) ? src_third_divider : src_first_divider))
    else $error("output one source wrong");
  src_two_a: assert property (wr_at(OFS_OUT_TWO) |=>
    out_two_source == ($past(reg_wdata[7]) ? src_third_divider : src_first_divider))
    else $error("output two source wrong");
  type_one_a: assert property (wr_at(OFS_OUT_ONE) |=>
    out_one_driver_type == $past(reg_wdata[5:4])) else $error("output one type wrong");
  slew_one_a: assert property (wr_at(OFS_OUT_ONE) |=>
    out_one_slew_strength == ($past(reg_wdata[1]) && $past(reg_wdata[5:4]) == 2'h0))
    else $error("output one slew wrong");
  leg_two_a: assert property (wr_at(OFS_OUT_TWO) |=>
    out_two_second_leg_enable == ($past(reg_wdata[0]) && $past(reg_wdata[5:4]) == 2'h0))
    else $error("output two second leg wrong");
  power_down_a: assert property (wr_at(OFS_SINGLE) |=>
    chip_power_down == !$past(reg_wdata[7])) else $error("power down wrong");
  single_src_a: assert property (wr_at(OFS_SINGLE) ##1 !single_out_slow_freerun |->
    single_out_source == ($past(reg_wdata[3]) ? src_fourth_divider : src_fifth_divider))
    else $error("single output source wrong");
  chan_a_a: assert property (wr_at(OFS_SINGLE) |=>
    fourth_divider_channel_a_enable == $past(reg_wdata[0])) else $error("channel a wrong");
  reset_val_a: assert property ($fell(rst) |-> out_one_source == src_third_divider &&
    out_two_source == src_first_divider && !chip_power_down && single_out_slow_freerun)
    else $error("reset values wrong");
endmodule

bind clock_output_control_regs clkout_regs_asserts clkout_regs_asserts_inst (.*);

`default_nettype wire

//--- dv/clock_output_control_regs_bench.sv
`default_nettype none

module clock_output_control_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import clkout_regs_pkg::*;
  logic         sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0;
  logic [7:0]   reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rd_val;
  source_t      out_one_source, out_two_source, single_out_source;
  driver_type_t out_one_driver_type, out_two_driver_type;
  logic         out_one_slew_strength, out_one_second_leg_enable, out_two_slew_strength;
  logic         out_two_second_leg_enable, chip_power_down, single_out_slow_freerun;
  logic         ref_out_freerun, ref_out_enable, fourth_divider_channel_a_enable;
  logic         fourth_divider_channel_b_enable;
  int           error_cnt = 0, n_tests = 0;

  clock_output_control_regs clock_output_control_regs_inst (.*);

  always #50 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Access and compare helpers
  // ----------------------------------------
  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Strobe stays high so writes can run back to back
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge sys_clk);
  endtask
  task automatic rd(input logic [7:0] a);
    reg_wr = 1'b0;
    reg_addr = a;
    @(negedge sys_clk);
    rd_val = reg_rdata;
  endtask
  function automatic logic [7:0] kept(logic [7:0] d, logic [7:0] r, logic [7:0] m);
    return (d & m) | (r & ~m);
  endfunction

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic test_reset;
    rd(OFS_OUT_ONE);
    chk("rd one", rd_val, RST_OUT_ONE);
    rd(OFS_OUT_TWO);
    chk("rd two", rd_val, RST_OUT_TWO);
    rd(OFS_SINGLE);
    chk("rd single", rd_val, RST_SINGLE);
    chk("type one rst", out_one_driver_type, low_power_hcsl_type);
    chk("type two rst", out_two_driver_type, low_power_hcsl_type);
    chk("single src rst", single_out_source, src_fourth_divider);
    chk("ref enable rst", ref_out_enable, 8'h01);
    $display("reset test done");
  endtask
  task automatic test_diff;
    logic [7:0] d;
    // Reserved bits written at their reset values; slew and leg bits alternate
    for (int t = 0; t < 8; t++) begin
      d = {t[0], 1'b0, t[1:0], 2'h1, t[2], !t[2]};
      wr(OFS_OUT_ONE, d);
      wr(OFS_OUT_TWO, d ^ 8'hf0);
      chk("src one", out_one_source, 8'(t[0]));
      chk("src two", out_two_source, 8'(!t[0]));
      chk("type one", out_one_driver_type, 8'(t % 4));
      chk("type two", out_two_driver_type, 8'(3 - t % 4));
      chk("slew one", out_one_slew_strength, 8'(t == 4));
      chk("slew two", out_two_slew_strength, 8'(t == 7));
      chk("leg one", out_one_second_leg_enable, 8'(t == 0));
      chk("leg two", out_two_second_leg_enable, 8'(t == 3));
      rd(OFS_OUT_ONE);
      chk("rd one", rd_val, kept(d, RST_OUT_ONE, WMASK_OUT));
      rd(OFS_OUT_TWO);
      chk("rd two", rd_val, kept(d ^ 8'hf0, RST_OUT_TWO, WMASK_OUT));
    end
    $display("diff test done");
  endtask
  task automatic test_single;
    // Reserved bit 5 written as 0 in 8'hdf, as in every value; readback expects its reset value 0
    logic [7:0] v[4] = '{8'h18, 8'h91, 8'hdf, 8'h42};
    foreach (v[i]) begin
      wr(OFS_SINGLE, v[i]);
      rd(OFS_SINGLE);
      chk("rd single", rd_val, kept(v[i], RST_SINGLE, WMASK_SGL));
      chk("power down", chip_power_down, 8'(!v[i][7]));
      chk("freerun", single_out_slow_freerun, 8'(!v[i][4]));
      if (v[i][4]) begin
        chk("single src", single_out_source, v[i][3] ? 8'h02 : 8'h03);
      end
      chk("chan a", fourth_divider_channel_a_enable, 8'(v[i][0]));
      chk("chan b", fourth_divider_channel_b_enable, 8'(v[i][1]));
      chk("ref freerun", ref_out_freerun, 8'(v[i][6]));
      chk("ref enable", ref_out_enable, 8'(v[i][2]));
    end
    // Unmapped write must leave everything alone
    wr(8'h25, 8'h00);
    rd(OFS_SINGLE);
    chk("after unmapped", rd_val, kept(8'h42, RST_SINGLE, WMASK_SGL));
    rd(8'h25);
    chk("rd unmapped", rd_val, 8'h00);
    $display("single test done");
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (12) @(negedge sys_clk);
    rst = 1'b0;
    test_reset();
    test_diff();
    test_single();
    print_verdict();
  end
endmodule

`default_nettype wire
